// ---- rtl/cse_exec.v ----
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "cse_regs.vh"

// Functional notes
// - equal compare 0x31: file minus accumulator, no store; skip next if equal
// - greater compare 0x32: unsigned; skip next when file strictly greater
// - less compare 0x30: unsigned; skip next when file strictly less
// - bcd adjust decoded from 0010111, select bit, address; one cycle
// - low nibble plus 6 when above 9 or digit carry set
// - high nibble plus 6 when above 9 or carry; plus 7 if low also above 9
// - bcd result always to file; also accumulator when select bit is 0
// - decrement 0000011d: file minus one to acc or file; updates ovf, c, digit c, z
// - decrement-skip 0001011d: same destinations, no flag change
// - decrement-skip result zero discards next instruction; two cycles
module cse_exec (
  input  wire        core_clk_i,
  input  wire        rst_b_i,
  input  wire        instr_valid_i,
  input  wire [15:0] instr_i,
  output wire        instr_ready_o,
  output reg         discard_o,
  output reg  [1:0]  phase_o,
  output reg  [7:0]  file_addr_o,
  output reg         file_rd_o,
  input  wire [7:0]  file_rdata_i,
  output reg         file_we_o,
  output reg  [7:0]  file_wdata_o,
  output wire [7:0]  working_accumulator_o,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  reg        run_reg;
  reg        skipslot_reg;
  reg        skip_pend_reg;
  reg [15:0] instr_reg;
  reg [7:0]  acc_reg;
  reg        c_reg;
  reg        digc_reg;
  reg        z_reg;
  reg        ovf_reg;
  reg        unsup_reg;

  wire       is_eq;
  wire       is_gt;
  wire       is_lt;
  wire       is_bcd;
  wire       is_dec;
  wire       is_dsz;
  wire       dest_file;
  wire [7:0] op_addr;
  wire       known;

  cse_decode u_dec (
    .instr_i                      (instr_reg),
    .compare_skip_if_equal_o      (is_eq),
    .compare_skip_if_greater_o    (is_gt),
    .compare_skip_if_less_o       (is_lt),
    .decimal_adjust_accumulator_o (is_bcd),
    .decrement_file_o             (is_dec),
    .decrement_skip_on_zero_o     (is_dsz),
    .dest_file_o                  (dest_file),
    .file_addr_o                  (op_addr),
    .known_o                      (known)
  );

  // a live slot is one that is neither skipped nor unknown
  wire live = run_reg & ~skipslot_reg & known;
  wire is_cmp = is_eq | is_gt | is_lt;

  // next instruction is taken when idle or in the last phase
  assign instr_ready_o = ~run_reg | (phase_o == `CSE_PH_WRITE);
  wire take = instr_valid_i & instr_ready_o;

  // ****************************************************************
  // datapath
  // ****************************************************************
  wire [7:0] fv      = file_rdata_i;
  wire [7:0] dec_res = fv - 8'h01;

  wire       lo_big  = (acc_reg[3:0] > `CSE_BCD_LIMIT);
  wire       hi_big  = (acc_reg[7:4] > `CSE_BCD_LIMIT);
  wire       lo_adj  = lo_big | digc_reg;
  wire       hi_adj  = hi_big | c_reg;

  reg  [4:0] hi_add;
  always @*
  begin
    if (hi_adj & lo_big)
      hi_add = `CSE_BCD_ADD7;
    else if (hi_adj)
      hi_add = `CSE_BCD_ADD6;
    else
      hi_add = 5'h00;
  end

  wire [4:0] lo_sum  = {1'b0, acc_reg[3:0]} + (lo_adj ? `CSE_BCD_ADD6 : 5'h00);
  wire [4:0] hi_sum  = {1'b0, acc_reg[7:4]} + hi_add;
  wire [7:0] bcd_res = {hi_sum[3:0], lo_sum[3:0]};

  // unsigned compare of file value against accumulator
  reg skip_hit;
  always @*
  begin
    skip_hit = 1'b0;
    if (is_eq)
      skip_hit = (fv == acc_reg);
    else if (is_gt)
      skip_hit = (fv > acc_reg);
    else if (is_lt)
      skip_hit = (fv < acc_reg);
    else if (is_dsz)
      skip_hit = (dec_res == 8'h00);
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  wire hit_acc   = (paddr_i == `CSE_ADDR_ACC);
  wire hit_flags = (paddr_i == `CSE_ADDR_FLAGS);
  wire hit_state = (paddr_i == `CSE_ADDR_STATE);
  wire mapped    = hit_acc | hit_flags | hit_state;
  wire acc_phase = psel_i & penable_i;
  wire wr_ok     = acc_phase & pwrite_i & mapped;

  // zero wait states; data was captured in setup
  assign pready_o  = 1'b1;
  assign pslverr_o = acc_phase & ~mapped;

  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (hit_acc)
      rd_mux[7:0] = acc_reg;
    else if (hit_flags)
      rd_mux[3:0] = {ovf_reg, z_reg, digc_reg, c_reg};
    else if (hit_state)
      rd_mux[4:0] = {unsup_reg, skip_pend_reg, run_reg, phase_o};
  end

  assign working_accumulator_o = acc_reg;

  // ****************************************************************
  // sequencer, execution and register writes
  // ****************************************************************
  wire in_proc = live & (phase_o == `CSE_PH_PROCESS);

  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      run_reg       <= 1'b0;
      skipslot_reg  <= 1'b0;
      skip_pend_reg <= 1'b0;
      instr_reg     <= 16'h0000;
      phase_o       <= `CSE_PH_DECODE;
      discard_o     <= 1'b0;
      file_addr_o   <= 8'h00;
      file_rd_o     <= 1'b0;
      file_we_o     <= 1'b0;
      file_wdata_o  <= 8'h00;
      acc_reg       <= `CSE_RST_ACC;
      {ovf_reg, z_reg, digc_reg, c_reg} <= `CSE_RST_FLAGS;
      unsup_reg     <= 1'b0;
      prdata_o      <= 32'h0000_0000;
    end
    else
    begin
      discard_o <= 1'b0;
      file_rd_o <= 1'b0;
      file_we_o <= 1'b0;

      // register reads are sampled in the setup cycle
      if (psel_i & ~penable_i)
        prdata_o <= rd_mux;

      // software writes; execution below overrides on a clash
      if (wr_ok & hit_acc)
        acc_reg <= pwdata_i[7:0];
      if (wr_ok & hit_flags)
      begin
        c_reg    <= pwdata_i[`CSE_FLAG_C];
        digc_reg <= pwdata_i[`CSE_FLAG_DIGC];
        z_reg    <= pwdata_i[`CSE_FLAG_Z];
        ovf_reg  <= pwdata_i[`CSE_FLAG_OVF];
      end
      if (wr_ok & hit_state & pwdata_i[`CSE_ST_UNSUP])
        unsup_reg <= 1'b0;

      // slot sequencing
      if (take)
      begin
        run_reg       <= 1'b1;
        phase_o       <= `CSE_PH_DECODE;
        instr_reg     <= instr_i;
        // prefetched word is dropped and its slot runs empty
        skipslot_reg  <= skip_pend_reg;
        discard_o     <= skip_pend_reg;
        skip_pend_reg <= 1'b0;
      end
      else if (run_reg)
      begin
        phase_o <= phase_o + 2'h1;
        if (phase_o == `CSE_PH_WRITE)
          run_reg <= 1'b0;
      end

      // decode phase: present address, read during read phase
      if (live & (phase_o == `CSE_PH_DECODE))
      begin
        file_addr_o <= op_addr;
        file_rd_o   <= 1'b1;
      end

      // flag set wins over a software clear in the same cycle
      if (run_reg & ~skipslot_reg & ~known & (phase_o == `CSE_PH_DECODE))
        unsup_reg <= 1'b1;

      // process phase: result registered, written in write phase
      if (in_proc)
      begin
        skip_pend_reg <= skip_hit;
        if (is_bcd)
        begin
          file_we_o    <= 1'b1;
          file_wdata_o <= bcd_res;
          if (!dest_file)
            acc_reg <= bcd_res;
          // carry out is or-ed so an incoming carry survives
          c_reg <= hi_sum[4] | c_reg;
        end
        else if (is_dec | is_dsz)
        begin
          if (dest_file)
          begin
            file_we_o    <= 1'b1;
            file_wdata_o <= dec_res;
          end
          else
            acc_reg <= dec_res;
          if (is_dec)
          begin
            // carry means no borrow
            c_reg    <= (fv != 8'h00);
            digc_reg <= (fv[3:0] != 4'h0);
            z_reg    <= (dec_res == 8'h00);
            ovf_reg  <= (fv == 8'h80);
          end
        end
        // compares: no write and no flag change
        else if (is_cmp)
          file_we_o <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // phase map of a live slot
  // ****************************************************************
  // decode   : address registered, read strobe raised
  // read     : file_rd_o high, file answers one cycle later
  // process  : file_rdata_i used, results registered at the edge
  // write    : file_we_o high for one cycle, acc and flags updated
  // a skipped slot runs four empty phases, and being
  // followed by a skip itself is impossible since no skip
  // is decided in an empty slot

endmodule // cse_exec

// ---- rtl/cse_regs.vh ----
`ifndef CSE_REGS_VH
`define CSE_REGS_VH

// ****************************************************************
// opcode fields
// ****************************************************************
`define CSE_OP_CMP_LT      8'h30
`define CSE_OP_CMP_EQ      8'h31
`define CSE_OP_CMP_GT      8'h32
`define CSE_OP_BCD_ADJ     7'h17
`define CSE_OP_DEC         7'h03
`define CSE_OP_DEC_SKZ     7'h0B

// ****************************************************************
// bcd adjust constants
// ****************************************************************
`define CSE_BCD_LIMIT      4'h9
`define CSE_BCD_ADD6       5'h06
`define CSE_BCD_ADD7       5'h07

// ****************************************************************
// phase codes of one instruction cycle
// ****************************************************************
`define CSE_PH_DECODE      2'h0
`define CSE_PH_READ        2'h1
`define CSE_PH_PROCESS     2'h2
`define CSE_PH_WRITE       2'h3

// ****************************************************************
// apb register map
// ****************************************************************
`define CSE_ADDR_ACC       8'h00
`define CSE_ADDR_FLAGS     8'h04
`define CSE_ADDR_STATE     8'h08

`define CSE_FLAG_C         0
`define CSE_FLAG_DIGC      1
`define CSE_FLAG_Z         2
`define CSE_FLAG_OVF       3

`define CSE_ST_BUSY        2
`define CSE_ST_SKIP        3
`define CSE_ST_UNSUP       4

`define CSE_RST_ACC        8'h00
`define CSE_RST_FLAGS      4'h0

`endif

// ---- rtl/cse_decode.v ----
`timescale 1ns/10ps
`include "cse_regs.vh"

// ****************************************************************
// opcode decoder for the compare, bcd and decrement slice
// ****************************************************************
module cse_decode (
  input  wire [15:0] instr_i,
  output wire        compare_skip_if_equal_o,
  output wire        compare_skip_if_greater_o,
  output wire        compare_skip_if_less_o,
  output wire        decimal_adjust_accumulator_o,
  output wire        decrement_file_o,
  output wire        decrement_skip_on_zero_o,
  output wire        dest_file_o,
  output wire [7:0]  file_addr_o,
  output wire        known_o
);

  assign compare_skip_if_equal_o      = (instr_i[15:8] == `CSE_OP_CMP_EQ);
  assign compare_skip_if_greater_o    = (instr_i[15:8] == `CSE_OP_CMP_GT);
  assign compare_skip_if_less_o       = (instr_i[15:8] == `CSE_OP_CMP_LT);
  assign decimal_adjust_accumulator_o = (instr_i[15:9] == `CSE_OP_BCD_ADJ);
  assign decrement_file_o             = (instr_i[15:9] == `CSE_OP_DEC);
  assign decrement_skip_on_zero_o     = (instr_i[15:9] == `CSE_OP_DEC_SKZ);
  assign dest_file_o                  = instr_i[8];
  // full byte address, any of 256 locations
  assign file_addr_o                  = instr_i[7:0];
  assign known_o = compare_skip_if_equal_o | compare_skip_if_greater_o | compare_skip_if_less_o |
                   decimal_adjust_accumulator_o | decrement_file_o | decrement_skip_on_zero_o;

endmodule // cse_decode

// ---- verification/cse_file_model.sv ----
`timescale 1ns/10ps
// ********************
// data file memory
// ********************
module cse_file_model (
  input  wire       core_clk_i,
  input  wire [7:0] file_addr_i,
  input  wire       file_rd_i,
  input  wire       file_we_i,
  input  wire [7:0] file_wdata_i,
  output reg  [7:0] file_rdata_o
);
  reg [7:0] data_reg [0:255];
  initial file_rdata_o = 8'h00;
  always @(posedge core_clk_i)
  begin
    if (file_we_i)
      data_reg[file_addr_i] <= file_wdata_i;
    // data valid only in the cycle after a read, toggles otherwise
    if (file_rd_i)
      file_rdata_o <= data_reg[file_addr_i];
    else
      file_rdata_o <= ~file_rdata_o;
  end
endmodule // cse_file_model

// ---- verification/cse_exec_properties.sv ----
`timescale 1ns/10ps
`include "cse_regs.vh"
module cse_exec_properties (
  input wire        core_clk_i,
  input wire        rst_b_i,
  input wire        instr_valid_i,
  input wire [15:0] instr_i,
  input wire        instr_ready_o,
  input wire        discard_o,
  input wire [1:0]  phase_o,
  input wire        file_rd_o,
  input wire [7:0]  file_rdata_i,
  input wire        file_we_o,
  input wire [7:0]  file_wdata_o,
  input wire [7:0]  working_accumulator_o
);
  reg  [15:0] cur_reg;
  reg         rd_d_reg;
  reg         rd_dd_reg;
  wire        take = instr_valid_i & instr_ready_o;
  wire [7:0]  op8  = cur_reg[15:8];
  wire [7:0]  fd   = file_rdata_i;
  wire [7:0]  acc  = working_accumulator_o;
  wire        is_dec = (cur_reg[15:9] == `CSE_OP_DEC) || (cur_reg[15:9] == `CSE_OP_DEC_SKZ);
  wire        is_cmp = (op8 == `CSE_OP_CMP_LT) || (op8 == `CSE_OP_CMP_EQ) || (op8 == `CSE_OP_CMP_GT);
  wire        hit = rd_d_reg && ((op8 == `CSE_OP_CMP_EQ && fd == acc) || (op8 == `CSE_OP_CMP_GT && fd > acc)
                    || (op8 == `CSE_OP_CMP_LT && fd < acc) || (cur_reg[15:9] == `CSE_OP_DEC_SKZ && fd == 8'h01));
  always @(posedge core_clk_i)
  begin
    rd_d_reg  <= rst_b_i & file_rd_o;
    rd_dd_reg <= rst_b_i & rd_d_reg;
    if (take)
      cur_reg <= instr_i;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ********************
  // slot timing and effects
  // ********************
  phase_order_a: assert property (take |=> phase_o == 2'h0 ##1 phase_o == 2'h1
    ##1 phase_o == 2'h2 ##1 phase_o == 2'h3) else $error("phase order wrong");
  slot_length_a: assert property (take |=> !instr_ready_o [*3] ##1 instr_ready_o)
    else $error("slot not one cycle of four phases");
  skip_quiet_a: assert property (discard_o |-> (!file_rd_o && !file_we_o) [*4])
    else $error("discarded slot touched the file");
  cmp_no_write_a: assert property (rd_dd_reg && is_cmp |-> !file_we_o)
    else $error("compare wrote the file");
  bcd_writes_a: assert property (rd_dd_reg && cur_reg[15:9] == `CSE_OP_BCD_ADJ |-> file_we_o)
    else $error("bcd adjust did not write the file");
  dec_wdata_a: assert property (file_we_o && is_dec |-> file_wdata_o == $past(file_rdata_i) - 8'h01)
    else $error("decrement write data wrong");
  dec_acc_a: assert property (rd_dd_reg && is_dec && !cur_reg[8] |-> acc == $past(file_rdata_i) - 8'h01)
    else $error("decrement accumulator wrong");
  skip_taken_a: assert property (hit |-> ##[2:6] discard_o)
    else $error("skip not taken");
  skip_absent_a: assert property (rd_d_reg && !hit |-> ##1 (!discard_o) [*5])
    else $error("unexpected skip");
  cover property (hit);
  cover property (discard_o);
  cover property (file_we_o && is_dec);
endmodule // cse_exec_properties

bind cse_exec cse_exec_properties u_cse_exec_properties (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_ready_o(instr_ready_o), .discard_o(discard_o),
  .phase_o(phase_o), .file_rd_o(file_rd_o), .file_rdata_i(file_rdata_i), .file_we_o(file_we_o),
  .file_wdata_o(file_wdata_o), .working_accumulator_o(working_accumulator_o));

// ---- verification/cse_exec_tb.sv ----
`timescale 1ns/10ps
`include "cse_regs.vh"
module cse_exec_tb;
  reg         core_clk_i = 1'b0;
  reg         rst_b_i    = 1'b0;
  reg         valid      = 1'b0;
  reg  [15:0] instr      = 16'h0000;
  reg         psel       = 1'b0;
  reg         penable    = 1'b0;
  reg         pwrite     = 1'b0;
  reg  [7:0]  paddr      = 8'h00;
  reg  [31:0] pwdata     = 32'h0;
  wire        ready, frd, fwe, pready, perr;
  wire [7:0]  faddr, frdata, fwdata, acc;
  wire [31:0] prdata;
  reg  [31:0] r;
  reg         e;
  integer     bad_count = 0;
  integer     n_tests   = 0;
  integer     cyc       = 0;
  integer     i, j;
  cse_exec u_cse_exec (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .instr_valid_i(valid), .instr_i(instr),
    .instr_ready_o(ready), .discard_o(), .phase_o(), .file_addr_o(faddr), .file_rd_o(frd),
    .file_rdata_i(frdata), .file_we_o(fwe), .file_wdata_o(fwdata), .working_accumulator_o(acc),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr));
  cse_file_model u_cse_file_model (.core_clk_i(core_clk_i), .file_addr_i(faddr), .file_rd_i(frd),
    .file_we_i(fwe), .file_wdata_i(fwdata), .file_rdata_o(frdata));
  initial forever #25 core_clk_i = ~core_clk_i;
  // ********************
  // shared tasks
  // ********************
  task final_report;
  begin
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count = bad_count + 1;
      final_report;
    end
  end
  task chk(input [8*6-1:0] nm, input [31:0] ex, input [31:0] got);
  begin
    n_tests = n_tests + 1;
    if (got !== ex)
    begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, ex, got);
    end
  end
  endtask
  // leaves one idle edge before setup so back-to-back calls never reassign in one step
  task apb(input wr, input [7:0] a, input [31:0] d);
  begin
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    @(negedge core_clk_i);
    while (pready !== 1'b1) @(negedge core_clk_i);
    e = perr;
    @(posedge core_clk_i);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task rchk(input [7:0] a, input [31:0] ex, input [8*6-1:0] nm);
  begin
    apb(1'b0, a, 32'h0);
    chk(nm, ex, r);
  end
  endtask
  task issue(input [15:0] w);
  begin
    valid <= 1'b1;
    instr <= w;
    @(negedge core_clk_i);
    while (ready !== 1'b1) @(negedge core_clk_i);
    @(posedge core_clk_i);
  end
  endtask
  task idle;
  begin
    valid <= 1'b0;
    repeat (5) @(posedge core_clk_i);
  end
  endtask
  // ********************
  // scenarios
  // ********************
  task s_dec;
  begin
    u_cse_file_model.data_reg[8'h10] = 8'h80;
    u_cse_file_model.data_reg[8'hFF] = 8'h00;
    issue({`CSE_OP_DEC, 1'b1, 8'h10});
    idle;
    chk("dmem", 32'h7F, u_cse_file_model.data_reg[8'h10]);
    rchk(`CSE_ADDR_FLAGS, 32'h9, "dflg");
    issue({`CSE_OP_DEC, 1'b0, 8'hFF});
    idle;
    rchk(`CSE_ADDR_ACC, 32'hFF, "dacc");
    rchk(`CSE_ADDR_FLAGS, 32'h0, "dflg0");
  end
  endtask
  task s_skz;
  begin
    u_cse_file_model.data_reg[8'h30] = 8'h01;
    u_cse_file_model.data_reg[8'h31] = 8'h05;
    u_cse_file_model.data_reg[8'h32] = 8'h03;
    apb(1'b1, `CSE_ADDR_FLAGS, 32'hF);
    issue({`CSE_OP_DEC_SKZ, 1'b1, 8'h30});
    issue({`CSE_OP_DEC, 1'b1, 8'h31});
    issue({`CSE_OP_DEC_SKZ, 1'b0, 8'h32});
    issue({`CSE_OP_CMP_EQ, 8'h30});
    idle;
    chk("zmem", 32'h0, u_cse_file_model.data_reg[8'h30]);
    chk("zskip", 32'h5, u_cse_file_model.data_reg[8'h31]);
    rchk(`CSE_ADDR_ACC, 32'h2, "zacc");
    rchk(`CSE_ADDR_FLAGS, 32'hF, "zflg");
  end
  endtask
  task s_cmp;
  begin
    apb(1'b1, `CSE_ADDR_ACC, 32'h40);
    apb(1'b1, `CSE_ADDR_FLAGS, 32'h5);
    for (i = 0; i < 3; i = i + 1)
      for (j = 0; j < 3; j = j + 1)
      begin
        u_cse_file_model.data_reg[8'hE1] = 8'h3F + j[7:0];
        u_cse_file_model.data_reg[8'h50] = 8'h10;
        issue({6'h0C, i[1:0], 8'hE1});
        issue({`CSE_OP_DEC_SKZ, 1'b1, 8'h50});
        idle;
        chk("cskip", (i == j) ? 32'h10 : 32'h0F, u_cse_file_model.data_reg[8'h50]);
      end
    rchk(`CSE_ADDR_FLAGS, 32'h5, "cflg");
  end
  endtask
  task s_bcd;
  begin
    apb(1'b1, `CSE_ADDR_ACC, 32'hA5);
    apb(1'b1, `CSE_ADDR_FLAGS, 32'h0);
    issue({`CSE_OP_BCD_ADJ, 1'b0, 8'h20});
    idle;
    chk("bmem", 32'h05, u_cse_file_model.data_reg[8'h20]);
    rchk(`CSE_ADDR_ACC, 32'h05, "bacc");
    rchk(`CSE_ADDR_FLAGS, 32'h1, "bflg");
    apb(1'b1, `CSE_ADDR_ACC, 32'h14);
    apb(1'b1, `CSE_ADDR_FLAGS, 32'h2);
    issue({`CSE_OP_BCD_ADJ, 1'b1, 8'h21});
    idle;
    chk("bmem1", 32'h1A, u_cse_file_model.data_reg[8'h21]);
    rchk(`CSE_ADDR_ACC, 32'h14, "bacc1");
    rchk(`CSE_ADDR_FLAGS, 32'h2, "bflg1");
    apb(1'b1, 8'h40, 32'h0);
    chk("perr", 32'h1, {31'h0, e});
  end
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    s_dec;
    s_skz;
    s_cmp;
    s_bcd;
    final_report;
  end
endmodule // cse_exec_tb
